// *** include/uart_pkg.sv ***
// uart_pkg: register map, field positions, reset values and timing counts
// for the serial port core. assumes a 32-bit axi4-lite register bus.
`default_nettype none
package uart_pkg;
  // register byte offsets
  localparam logic [7:0] BUF_OFF   = 8'h00;  // serial_buffer_reg
  localparam logic [7:0] CTRL_OFF  = 8'h04;  // serial_control_reg
  localparam logic [7:0] PWR_OFF   = 8'h08;  // power_control_reg
  localparam logic [7:0] RELOAD_OFF = 8'h0c; // bit rate reload count
  // serial_control_reg fields
  localparam int CTRL_TXF  = 0;  // tx_complete_flag
  localparam int CTRL_RXF  = 1;  // rx_complete_flag
  localparam int CTRL_REN  = 2;  // receive enable
  localparam int CTRL_R9   = 3;  // rx_ninth_bit
  localparam int CTRL_MPQ  = 4;  // multiproc_qualify_bit
  localparam int CTRL_MODE = 5;  // 0 shift mode, 1 ten-bit mode
  localparam int CTRL_TXA  = 6;  // transmit active (read only)
  localparam int CTRL_RXA  = 7;  // receive active (read only)
  localparam int PWR_DBL   = 0;  // baud_double_bit
  localparam logic [7:0] RELOAD_RST = 8'h01;
  // machine cycle: six states of one clock each, so shift rate is clock / 6;
  // both phases of a state share its single clock
  localparam logic [3:0] PH_LAST  = 4'h5;  // s6p2
  localparam logic [3:0] PH_S1P1  = 4'h0;
  localparam logic [3:0] PH_S3P1  = 4'h2;
  localparam logic [3:0] PH_S5P2  = 4'h4;
  localparam logic [3:0] PH_S6P1  = 4'h5;
  // timer1 prescale: 192 clocks = 16 ticks * 12, halved with doubling
  localparam logic [3:0] PRE_FULL = 4'hb;  // divide by 12 (plain rate)
  localparam logic [3:0] PRE_HALF = 4'h5;  // divide by 6 (doubled rate)
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : uart_pkg
`default_nettype wire

// *** hw/uart_core.sv ***
// uart_core: serial port with synchronous shift mode and ten-bit async mode,
// registers on axi4-lite. assumes core_clk is the cpu clock; shift_data_pin
// and rx pin are asynchronous and synchronised here.
// Behaviour
// - shift mode moves eight bits lsb first, clock on shift_clock_pin, cpu clock / 6
// - buffer write in shift mode loads marker, transmit starts one machine cycle later
// - shift clock low s3..s5, high s6..s2; transmit shifts right at s6p2
// - zeros fill from left; marker beside msb ends send, sets tx flag
// - receive starts with enable set and rx flag clear; preload 11111110
// - receive shift clock toggles s3p1/s6p1; shift left at s6p2 with s5p2 sample
// - preload zero at left ends receive, loads buffer, sets rx flag
// - async frame is start 0, 8 data lsb first, stop 1; stop stored as ninth bit
// - async bit rate comes from timer 1 overflow
// - async buffer write requests; start at next divide-by-16 rollover
// - send drives start bit; data enabled a bit later; first shift a bit after
// - marker alone at bit 0 (stop bit sent): final shift, end send, set tx flag
// - receiver samples at 16x; falling edge resets counter, loads 1ff
// - samples at counter states 6, 7, 8 with majority vote
// - start bit majority not zero: abandon and hunt again
// - nine-bit receive register; start bit at left triggers final shift
// - load only if rx flag clear and qualify clear or stop one
// - baud doubling bit resets to zero and doubles the rate
// - rate = clock / 192 (or 96) / reload count
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
module uart_core (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rxd_in,
  output logic             txd_out,
  input  wire logic        shift_data_pin_in,
  output logic             shift_data_pin_out,
  output logic             shift_data_pin_oe,
  output logic             shift_clock_pin
);
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_RUN = 2'b10} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_ARM = 2'b01, RX_RUN = 2'b10} rx_state_t;

  logic [7:0]  serial_buffer_reg;     // receive side
  logic [7:0]  reload_reg;
  logic        tx_complete_flag;
  logic        rx_complete_flag;
  logic        ren_reg;
  logic        rx_ninth_bit;
  logic        multiproc_qualify_bit;
  logic        mode_reg;
  logic        baud_double_bit;
  logic [3:0]  phase_reg;
  logic [3:0]  pre_reg;
  logic [7:0]  t1_reg;
  logic        tick16;
  logic [3:0]  txdiv_reg;
  logic        roll;
  logic [2:0]  rx_sync_reg;
  logic [2:0]  sd_sync_reg;
  logic        rx_pin;
  logic        sd_pin;
  tx_state_t   tx_state;
  rx_state_t   rx_state;
  logic [8:0]  tx_shift_reg;
  logic        tx_data_en;
  logic        tx_start_seen;
  logic [8:0]  rx_shift_reg;
  logic [3:0]  rx_div_reg;
  logic [2:0]  vote_reg;
  logic        rx_prev_reg;
  logic        m0_sample_reg;
  logic        aw_hold, w_hold;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic        buf_wr;
  logic        ctrl_wr;
  logic        rx_start_m0;
  logic        m0_end_rx;
  logic        a_rx_done;
  logic        tx_set, rx_set;

  // majority of three votes
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  // lines send lsb first but the shift registers fill from bit 0 upward
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8

  // pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_reg <= 3'h7;
      sd_sync_reg <= 3'h7;
      rx_pin      <= 1'b1;
      sd_pin      <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rxd_in};
      sd_sync_reg <= {sd_sync_reg[1:0], shift_data_pin_in};
      if (rx_sync_reg[1] == rx_sync_reg[2]) rx_pin <= rx_sync_reg[2];
      if (sd_sync_reg[1] == sd_sync_reg[2]) sd_pin <= sd_sync_reg[2];
    end
  end

  // machine-cycle state counter, 6 clocks per cycle, one shift per cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) phase_reg <= 4'h0;
    else if (phase_reg == uart_pkg::PH_LAST) phase_reg <= 4'h0;
    else phase_reg <= phase_reg + 4'h1;
  end

  // timer 1 stand-in: 16x tick = clock/12 (or /6) per reload count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= 4'h0;
      t1_reg  <= 8'h00;
      tick16  <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (pre_reg == (baud_double_bit ? uart_pkg::PRE_HALF : uart_pkg::PRE_FULL)) begin
        pre_reg <= 4'h0;
        if (t1_reg + 8'h01 >= reload_reg) begin
          t1_reg <= 8'h00;
          tick16 <= 1'b1;
        end else t1_reg <= t1_reg + 8'h01;
      end else pre_reg <= pre_reg + 4'h1;
    end
  end

  // transmit divide-by-16 counter; roll marks each bit boundary
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) txdiv_reg <= 4'h0;
    else if (tick16) txdiv_reg <= txdiv_reg + 4'h1;
  end
  assign roll = tick16 && (txdiv_reg == 4'hf);

  // axi write: address and data taken in either order, response after both
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign buf_wr  = wr_fire && aw_addr_reg == uart_pkg::BUF_OFF && w_strb_reg[0];
  assign ctrl_wr = wr_fire && aw_addr_reg == uart_pkg::CTRL_OFF && w_strb_reg[0];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold <= 1'b0; w_hold <= 1'b0;
      aw_addr_reg <= 8'h00; w_data_reg <= 32'h0000_0000; w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= uart_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > uart_pkg::RELOAD_OFF || aw_addr_reg[1:0] != 2'b00)
                        ? uart_pkg::AXI_SLVERR : uart_pkg::AXI_OKAY;
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // axi read: one cycle to accept, data on the next
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= uart_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= uart_pkg::AXI_OKAY;
        unique case (s_axi_araddr)
          uart_pkg::BUF_OFF:    s_axi_rdata <= {24'h000000, serial_buffer_reg};
          uart_pkg::CTRL_OFF:   s_axi_rdata <= {24'h000000, rx_state == RX_RUN, tx_state != TX_IDLE,
                                                mode_reg, multiproc_qualify_bit, rx_ninth_bit, ren_reg,
                                                rx_complete_flag, tx_complete_flag};
          uart_pkg::PWR_OFF:    s_axi_rdata <= {31'h0000_0000, baud_double_bit};
          uart_pkg::RELOAD_OFF: s_axi_rdata <= {24'h000000, reload_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= uart_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // software control bits; flags: hardware set wins over software clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ren_reg <= 1'b0; multiproc_qualify_bit <= 1'b0; mode_reg <= 1'b0;
      baud_double_bit <= 1'b0;
      reload_reg <= uart_pkg::RELOAD_RST;
      tx_complete_flag <= 1'b0; rx_complete_flag <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ren_reg  <= w_data_reg[uart_pkg::CTRL_REN];
        multiproc_qualify_bit <= w_data_reg[uart_pkg::CTRL_MPQ];
        mode_reg <= w_data_reg[uart_pkg::CTRL_MODE];
      end
      if (wr_fire && aw_addr_reg == uart_pkg::PWR_OFF && w_strb_reg[0])
        baud_double_bit <= w_data_reg[uart_pkg::PWR_DBL];
      if (wr_fire && aw_addr_reg == uart_pkg::RELOAD_OFF && w_strb_reg[0])
        reload_reg <= (w_data_reg[7:0] == 8'h00) ? 8'h01 : w_data_reg[7:0];
      if (tx_set) tx_complete_flag <= 1'b1;
      else if (ctrl_wr) tx_complete_flag <= w_data_reg[uart_pkg::CTRL_TXF];
      if (rx_set) rx_complete_flag <= 1'b1;
      else if (ctrl_wr) rx_complete_flag <= w_data_reg[uart_pkg::CTRL_RXF];
    end
  end

  // transmit machine, independent of receive
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= TX_IDLE; tx_shift_reg <= 9'h000; tx_data_en <= 1'b0;
      tx_start_seen <= 1'b0; tx_set <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (buf_wr) begin
        tx_shift_reg <= {1'b1, w_data_reg[7:0]};
        tx_state <= TX_WAIT; tx_data_en <= 1'b0; tx_start_seen <= 1'b0;
      end else unique case (tx_state)
        TX_IDLE: ;
        TX_WAIT: begin
          // shift mode: send one machine cycle after the write
          if (!mode_reg && phase_reg == uart_pkg::PH_LAST) tx_state <= TX_RUN;
          // async: start at the next divide-by-16 rollover
          if (mode_reg && roll) tx_state <= TX_RUN;
        end
        TX_RUN: begin
          if (!mode_reg) begin
            if (phase_reg == uart_pkg::PH_LAST) begin
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
              if (tx_shift_reg[8:1] == 8'h01) begin
                tx_state <= TX_IDLE; tx_set <= 1'b1;
              end
            end
          end else if (roll) begin
            if (!tx_start_seen) begin
              tx_start_seen <= 1'b1; tx_data_en <= 1'b1;
            end else begin
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
              if (tx_shift_reg[8:1] == 8'h00) begin
                tx_state <= TX_IDLE; tx_data_en <= 1'b0; tx_set <= 1'b1;
              end
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // shift-mode receive start condition and end detection
  assign rx_start_m0 = !mode_reg && ren_reg && !rx_complete_flag;
  assign m0_end_rx   = phase_reg == uart_pkg::PH_LAST && !rx_shift_reg[7];

  // async bit counter and majority voting window
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_div_reg <= 4'h0; vote_reg <= 3'h7; rx_prev_reg <= 1'b1; m0_sample_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_pin;
      if (mode_reg && rx_state == RX_IDLE && rx_prev_reg && !rx_pin) rx_div_reg <= 4'h0;
      else if (tick16) begin
        rx_div_reg <= rx_div_reg + 4'h1;
        if (rx_div_reg >= 4'h6 && rx_div_reg <= 4'h8)
          vote_reg <= {vote_reg[1:0], rx_pin};
      end
      if (phase_reg == uart_pkg::PH_S5P2) m0_sample_reg <= sd_pin;
    end
  end
  assign a_rx_done = tick16 && rx_div_reg == 4'hf;

  // receive machine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= RX_IDLE; rx_shift_reg <= 9'h1ff; rx_set <= 1'b0;
      serial_buffer_reg <= 8'h00; rx_ninth_bit <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      unique case (rx_state)
        RX_IDLE: begin
          // rx_set not yet in the flag: without this a finished receive re-arms
          if (rx_start_m0 && !rx_set) rx_state <= RX_ARM;
          else if (mode_reg && ren_reg && rx_prev_reg && !rx_pin) begin
            rx_shift_reg <= 9'h1ff; rx_state <= RX_RUN;
          end
        end
        RX_ARM: if (phase_reg == uart_pkg::PH_LAST) begin
          rx_shift_reg <= {1'b1, 8'hfe};
          rx_state <= RX_RUN;
        end
        RX_RUN: begin
          if (!mode_reg) begin
            if (phase_reg == uart_pkg::PH_LAST) begin
              rx_shift_reg <= {1'b1, rx_shift_reg[6:0], m0_sample_reg};
              if (m0_end_rx) begin
                serial_buffer_reg <= rev8({rx_shift_reg[6:0], m0_sample_reg});
                rx_set <= 1'b1; rx_state <= RX_IDLE;
              end
            end
          end else if (a_rx_done) begin
            if (rx_shift_reg == 9'h1ff && majority(vote_reg)) rx_state <= RX_IDLE;
            else if (!rx_shift_reg[8]) begin
              rx_state <= RX_IDLE;
              if (!rx_complete_flag && (!multiproc_qualify_bit || majority(vote_reg))) begin
                serial_buffer_reg <= rev8(rx_shift_reg[7:0]);
                rx_ninth_bit <= majority(vote_reg);
                rx_set <= 1'b1;
              end
            end else rx_shift_reg <= {rx_shift_reg[7:0], majority(vote_reg)};
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
  // pins: shift clock low s3..s5, high s6..s2 while active
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_clock_pin <= 1'b1; shift_data_pin_out <= 1'b1; shift_data_pin_oe <= 1'b0; txd_out <= 1'b1;
    end else begin
      shift_clock_pin <= !(!mode_reg && (tx_state == TX_RUN || rx_state == RX_RUN)
                           && phase_reg >= uart_pkg::PH_S3P1 && phase_reg < uart_pkg::PH_S6P1);
      shift_data_pin_oe  <= !mode_reg && tx_state == TX_RUN;
      shift_data_pin_out <= tx_shift_reg[0];
      txd_out <= !(mode_reg && tx_state == TX_RUN) ? 1'b1 : (tx_data_en ? tx_shift_reg[0] : 1'b0);
    end
  end
endmodule : uart_core
`default_nettype wire

// *** tb/uart_core_asserts.sv ***
// uart_core_asserts: port checks on the serial pins and register bus
// assumes one clock core_clk and the async active-low reset rstn
`default_nettype none
module uart_core_asserts (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        txd_out,
  input wire logic        shift_data_pin_out,
  input wire logic        shift_data_pin_oe,
  input wire logic        shift_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_len;
  logic [15:0] oe_len;
  // run lengths of a low line and of the send enable; both fit 16 bits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_len <= 16'h0000;
      oe_len  <= 16'h0000;
    end else begin
      low_len <= txd_out ? 16'h0000 : low_len + 16'h0001;
      oe_len  <= shift_data_pin_oe ? oe_len + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_sclk_low_span: assert property (
    $fell(shift_clock_pin) |-> !shift_clock_pin [*3] ##1 shift_clock_pin) else $error("shift clock low span");
  a_sclk_high_span: assert property (
    $rose(shift_clock_pin) |-> shift_clock_pin [*3]) else $error("shift clock high span");
  a_data_moves_high: assert property (
    shift_data_pin_oe && $past(shift_data_pin_oe) && $changed(shift_data_pin_out) |-> shift_clock_pin)
    else $error("shift data moved while clock low");
  a_send_length: assert property (
    $fell(shift_data_pin_oe) |-> oe_len >= 16'd48 && oe_len <= 16'd60) else $error("shift send length");
  a_bit_min_len: assert property (
    $rose(txd_out) |-> low_len >= 16'd96) else $error("serial low shorter than a bit");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : uart_core_asserts
bind uart_core uart_core_asserts u_uart_core_asserts (.core_clk(core_clk), .rstn(rstn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .txd_out(txd_out),
  .shift_data_pin_out(shift_data_pin_out), .shift_data_pin_oe(shift_data_pin_oe),
  .shift_clock_pin(shift_clock_pin));
`default_nettype wire

// *** tb/uart_serial_peer.sv ***
// uart_serial_peer: remote serial device and external shift register
// assumes bit_clks holds the current ten-bit mode bit time in clocks
`default_nettype none
module uart_serial_peer (
  input  wire logic        core_clk,
  input  wire logic [15:0] bit_clks,
  input  wire logic        txd_out,
  input  wire logic        shift_clock_pin,
  input  wire logic        shift_data_pin_out,
  input  wire logic        shift_data_pin_oe,
  output var  logic        rxd_in,
  output wire logic        data_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_src = 8'h00;
  logic [7:0] sh_cap = 8'h00;
  logic [7:0] tx_byte;
  logic       tx_stop;
  int         tx_count = 0;
  initial rxd_in = 1'b1;
  // wire level: the device while it drives, else the peer's next bit
  assign data_line = shift_data_pin_oe ? shift_data_pin_out : sh_src[0];
  // shift register on the rising shift clock; refill with changing bits
  always @(posedge shift_clock_pin) begin
    if (shift_data_pin_oe) sh_cap <= {shift_data_pin_out, sh_cap[7:1]};
    else sh_src <= {~sh_src[0], sh_src[7:1]};
  end
  // mid-bit decode: start, eight data lsb first, stop
  always @(negedge txd_out) begin
    repeat (bit_clks / 16'd2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge core_clk);
      tx_byte[i] = txd_out;
    end
    repeat (bit_clks) @(posedge core_clk);
    tx_stop = txd_out;
    tx_count++;
  end
  // one frame; a low stop bit is sent only when a scenario asks
  task automatic send_frame(input logic [7:0] d, input logic stop_bit);
    @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      rxd_in <= (i == 0) ? 1'b0 : (i == 9) ? stop_bit : d[i - 1];
      repeat (bit_clks) @(posedge core_clk);
    end
    rxd_in <= 1'b1;
    // idle half a bit so the receiver has settled before the caller looks
    repeat (bit_clks / 16'd2) @(posedge core_clk);
  endtask : send_frame
  // low pulse that ends before the vote samples, a false start
  task automatic glitch(input logic [15:0] n);
    @(posedge core_clk);
    rxd_in <= 1'b0;
    repeat (n) @(posedge core_clk);
    rxd_in <= 1'b1;
    repeat (2 * bit_clks) @(posedge core_clk);
  endtask : glitch
endmodule : uart_serial_peer
`default_nettype wire

// *** tb/uart_sync_and_async_modes_tb.sv ***
// uart_sync_and_async_modes_tb: random and corner traffic in both modes
// assumes uart_pkg offsets and the peer model beside the core
`default_nettype none
module uart_sync_and_async_modes_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rstn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
  logic        rxd, txd, sd_out, sd_oe, sclk, sd_line, dbl;
  logic [7:0]  awaddr, araddr, b, c, rl;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] bit_clks = 16'd192;
  int          failures = 0, samples_checked = 0, cyc = 0, n;
  integer      seed = 32'hd9970962;
  uart_core u_uart_core (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .rxd_in(rxd), .txd_out(txd), .shift_data_pin_in(sd_line),
    .shift_data_pin_out(sd_out), .shift_data_pin_oe(sd_oe), .shift_clock_pin(sclk));
  uart_serial_peer u_peer (.core_clk(core_clk), .bit_clks(bit_clks), .txd_out(txd), .shift_clock_pin(sclk),
    .shift_data_pin_out(sd_out), .shift_data_pin_oe(sd_oe), .rxd_in(rxd), .data_line(sd_line));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard: a frame is a few thousand clocks, the run well under this
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // ready is looked at mid-cycle, the request released after the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa | pw) begin
      @(negedge core_clk);
      if (awr) pa = 1'b0;
      if (wr) pw = 1'b0;
      @(posedge core_clk);
      if (!pa) awv <= 1'b0;
      if (!pw) wv <= 1'b0;
    end
    do @(negedge core_clk); while (!bv);
    @(posedge core_clk);
    bready <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge core_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(negedge core_clk); while (!arr);
    @(posedge core_clk);
    arv <= 1'b0;
    do @(negedge core_clk); while (!rv);
    v = rdata;
    e = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask : rd_reg
  task automatic wait_flag(input int f, output logic [31:0] v);
    v = 32'h0;
    for (int i = 0; i < 2000 && v[f] !== 1'b1; i++) rd_reg(uart_pkg::CTRL_OFF, v, r);
  endtask : wait_flag
  function automatic logic [31:0] ctl(input logic mode, input logic ren, input logic mpq);
    ctl = 32'h0;
    ctl[uart_pkg::CTRL_MODE] = mode;
    ctl[uart_pkg::CTRL_REN] = ren;
    ctl[uart_pkg::CTRL_MPQ] = mpq;
  endfunction : ctl
  function automatic logic [15:0] bit_time(input logic x2, input logic [7:0] k);
    bit_time = x2 ? 16'(96 * k) : 16'(192 * k);
  endfunction : bit_time
  task automatic results();
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    {rstn, awv, wv, bready, arv, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    // reset values, then an unmapped read that must be refused
    rd_reg(uart_pkg::PWR_OFF, d, r);
    check("double_rst", d, 32'h0);
    rd_reg(uart_pkg::RELOAD_OFF, d, r);
    check("reload_rst", d, {24'h0, uart_pkg::RELOAD_RST});
    rd_reg(8'h10, d, r);
    check("unmapped", {d[29:0], r}, {30'h0, uart_pkg::AXI_SLVERR});
    // shift mode send and receive, edge bytes first
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($random(seed));
      wr_reg(uart_pkg::CTRL_OFF, ctl(1'b0, 1'b0, 1'b0));
      wr_reg(uart_pkg::BUF_OFF, {24'h0, b});
      wait_flag(uart_pkg::CTRL_TXF, d);
      check("shift_tx", {24'h0, u_peer.sh_cap}, {24'h0, b});
      u_peer.sh_src = ~b;
      wr_reg(uart_pkg::CTRL_OFF, ctl(1'b0, 1'b1, 1'b0));
      wait_flag(uart_pkg::CTRL_RXF, d);
      check("shift_rx_flag", {31'h0, d[uart_pkg::CTRL_RXF]}, 32'h1);
      rd_reg(uart_pkg::BUF_OFF, d, r);
      check("shift_rx", d, {24'h0, ~b});
    end
    // ten-bit send at plain and doubled rates, then doubled with reload count 2
    for (int k = 0; k < 3; k++) begin
      dbl = (k != 0);
      rl = (k == 2) ? 8'h02 : 8'h01;
      wr_reg(uart_pkg::PWR_OFF, {31'h0, dbl});
      wr_reg(uart_pkg::RELOAD_OFF, {24'h0, rl});
      bit_clks = bit_time(dbl, rl);
      b = 8'($random(seed));
      n = u_peer.tx_count;
      wr_reg(uart_pkg::CTRL_OFF, ctl(1'b1, 1'b0, 1'b0));
      wr_reg(uart_pkg::BUF_OFF, {24'h0, b});
      wait_flag(uart_pkg::CTRL_TXF, d);
      repeat (bit_clks) @(posedge core_clk);
      check("async_tx", {23'h0, u_peer.tx_stop, u_peer.tx_byte}, {23'h0, 1'b1, b});
      check("async_frames", 32'(u_peer.tx_count - n), 32'h1);
    end
    // false start rejected, then a good frame with its stop bit kept
    wr_reg(uart_pkg::CTRL_OFF, ctl(1'b1, 1'b1, 1'b0));
    u_peer.glitch(bit_clks / 16'd4);
    rd_reg(uart_pkg::CTRL_OFF, d, r);
    check("false_start", {30'h0, d[uart_pkg::CTRL_RXA], d[uart_pkg::CTRL_RXF]}, 32'h0);
    b = 8'($random(seed));
    u_peer.send_frame(b, 1'b1);
    wait_flag(uart_pkg::CTRL_RXF, d);
    check("ninth_bit", {31'h0, d[uart_pkg::CTRL_R9]}, 32'h1);
    u_peer.send_frame(~b, 1'b1);
    rd_reg(uart_pkg::BUF_OFF, d, r);
    check("async_rx_kept", d, {24'h0, b});
    // qualify set and a low stop bit: frame dropped
    wr_reg(uart_pkg::CTRL_OFF, ctl(1'b1, 1'b1, 1'b1));
    u_peer.send_frame(8'h5a, 1'b0);
    rd_reg(uart_pkg::CTRL_OFF, d, r);
    check("qualify_drop", {31'h0, d[uart_pkg::CTRL_RXF]}, 32'h0);
    // receive and send overlapping
    wr_reg(uart_pkg::CTRL_OFF, ctl(1'b1, 1'b1, 1'b0));
    c = 8'($random(seed));
    fork
      u_peer.send_frame(b, 1'b1);
      wr_reg(uart_pkg::BUF_OFF, {24'h0, c});
    join
    wait_flag(uart_pkg::CTRL_TXF, d);
    repeat (bit_clks) @(posedge core_clk);
    check("duplex_tx", {24'h0, u_peer.tx_byte}, {24'h0, c});
    rd_reg(uart_pkg::BUF_OFF, d, r);
    check("duplex_rx", d, {24'h0, b});
    results();
  end
endmodule : uart_sync_and_async_modes_tb
`default_nettype wire
